// ===== rtl/rlcc_core_control.sv
// radio link core control register bank with wishbone slave and abort sequencing
// What this block does
// - writing one to bit 31 resets core except registers and timing, then self-clears
// - writing zero to any self-clearing action bit does nothing
// - writing one to bit 30 resets only the timing generator, then self-clears
// - writing one to bit 29 resets the register block except interrupt status
// - writing one to bit 28 raises the software interrupt if unmasked
// - writing one to bit 26 aborts the running rf test, then self-clears
// - endless transmit abort finishes current byte then the crc before stopping
// - endless receive abort finishes packet if access address seen, else stops rf
// - writing one to bit 25 ends the advertising event, then self-clears
// - writing one to bit 24 ends the scan window, then self-clears
// - more-data disable allows a single transmit/receive exchange per event
// - with more-data disabled tx flag comes from descriptor, rx flag only stored
// - sequence number disable sends descriptor sequence number as written
// - sequence number disable ignores received number, no sequence error
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
module rlcc_core_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // rf test engine status
  input wire logic rft_active_i,
  input wire logic rft_is_tx_i,
  input wire logic rft_bit_tick_i,
  input wire logic rft_aa_found_i,
  input wire logic rft_pkt_end_i,
  output logic rft_stop_o,
  output logic rf_off_o,
  // packet exchange
  input wire rlcc_pkg::rlcc_pkt_s pkt_i,
  input wire logic rx_done_i,
  input wire logic md_peer_i,
  output logic tx_md_o,
  output logic tx_sn_o,
  output logic rx_md_store_o,
  output logic sn_err_o,
  output logic more_exchange_o,
  // strobes and interrupts
  output rlcc_pkg::rlcc_strobe_s strobe_o,
  output logic software_irq_out,
  output logic irq_o
);
  logic [31:0] ctrl_q;
  logic [31:0] prio1_q;
  logic [31:0] ctrl2_q;
  logic [31:0] em_base_q;
  logic [rlcc_pkg::IRQ_W-1:0] stat_q;
  logic [rlcc_pkg::IRQ_W-1:0] mask_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  rlcc_pkg::rlcc_strobe_s strobe_q;
  rlcc_pkg::rlcc_rft_e rft_q;
  logic [4:0] rft_cnt_q;
  logic rft_stop_q;
  logic rf_off_q;

  // bus decode
  wire req = cyc_i && stb_i && !ack_q;
  wire wr = req && we_i;
  wire hit_ctrl = adr_i == rlcc_pkg::ADDR_CTRL;
  wire hit_stat = adr_i == rlcc_pkg::ADDR_IRQ_STAT;
  wire hit_ack = adr_i == rlcc_pkg::ADDR_IRQ_ACK;
  wire hit_mask = adr_i == rlcc_pkg::ADDR_IRQ_MASK;
  wire hit_prio1 = adr_i == rlcc_pkg::ADDR_PRIO1;
  wire hit_ctrl2 = adr_i == rlcc_pkg::ADDR_CTRL2;
  wire hit_em = adr_i == rlcc_pkg::ADDR_EM_BASE;
  wire hit_dbg = adr_i == rlcc_pkg::ADDR_DBG2 || adr_i == rlcc_pkg::ADDR_DBG3;
  wire hit_lstat = adr_i == rlcc_pkg::ADDR_LINK_STAT;
  wire mapped = hit_ctrl | hit_stat | hit_ack | hit_mask | hit_prio1 | hit_ctrl2 | hit_em | hit_dbg | hit_lstat;
  // byte lanes: an unselected lane keeps its stored bits in prio1, ctrl2 and em base, but is written as zero in ctrl and mask
  wire [31:0] bmask;
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign bmask[8*b+7:8*b] = {8{sel_i[b]}};
  end
  wire [31:0] wbits = dat_i & bmask;
  wire ctrl_wr = wr && hit_ctrl;

  // a zero written to an action bit never raises a strobe
  wire go_core = ctrl_wr && wbits[rlcc_pkg::BIT_CORE_RST];
  wire go_tg = ctrl_wr && wbits[rlcc_pkg::BIT_TG_RST];
  wire go_reg = ctrl_wr && wbits[rlcc_pkg::BIT_REG_RST];
  wire go_swi = ctrl_wr && wbits[rlcc_pkg::BIT_SWI];
  wire go_rft = ctrl_wr && wbits[rlcc_pkg::BIT_RFT_ABORT];
  wire go_adv = ctrl_wr && wbits[rlcc_pkg::BIT_ADV_ABORT];
  wire go_scan = ctrl_wr && wbits[rlcc_pkg::BIT_SCAN_ABORT];

  // an abort with no test running is dropped, it never waits for one
  wire rft_take = go_rft && rft_active_i;

  wire more_data_disable = ctrl_q[rlcc_pkg::BIT_MORE_DATA_DISABLE];
  wire seqnum_disable = ctrl_q[rlcc_pkg::BIT_SEQNUM_DISABLE];
  wire reg_rst = rst_i || ctrl_q[rlcc_pkg::BIT_REG_RST];

  // packet flag handling
  assign tx_md_o = more_data_disable ? pkt_i.tx_md : md_peer_i;
  assign more_exchange_o = !more_data_disable && (pkt_i.tx_md || pkt_i.rx_md);
  assign rx_md_store_o = pkt_i.rx_md;
  assign tx_sn_o = seqnum_disable ? pkt_i.tx_sn : pkt_i.exp_sn;
  wire sn_differs = pkt_i.rx_sn != pkt_i.exp_sn;
  wire sn_mismatch = rx_done_i && !seqnum_disable && sn_differs;
  assign sn_err_o = sn_mismatch;

  // interrupt events
  wire [rlcc_pkg::IRQ_W-1:0] ev;
  assign ev[rlcc_pkg::IRQ_SW] = ctrl_q[rlcc_pkg::BIT_SWI];
  assign ev[rlcc_pkg::IRQ_RFT_DONE] = rft_stop_q;
  assign ev[rlcc_pkg::IRQ_ADV_DONE] = strobe_q.adv_abort;
  assign ev[rlcc_pkg::IRQ_SCAN_DONE] = strobe_q.scan_abort;
  assign ev[rlcc_pkg::IRQ_SN_ERR] = sn_mismatch;
  wire [rlcc_pkg::IRQ_W-1:0] ack_clr = (wr && hit_ack) ? wbits[rlcc_pkg::IRQ_W-1:0] : '0;
  wire [rlcc_pkg::IRQ_W-1:0] pend = stat_q & mask_q;
  assign irq_o = |pend;
  assign software_irq_out = pend[rlcc_pkg::IRQ_SW];

  // read mux; strobe bits read zero: bits 29 and 28 are stored but masked out, the others are never stored
  wire [31:0] lstat = {28'h0000000, rft_q, rf_off_q, rft_stop_q};
  wire [31:0] rmux =
    hit_ctrl ? (ctrl_q & rlcc_pkg::CTRL_RW_MASK & ~(32'h1 << rlcc_pkg::BIT_REG_RST)) :
    hit_stat ? {27'h0000000, stat_q} :
    hit_mask ? {27'h0000000, mask_q} :
    hit_prio1 ? prio1_q :
    hit_ctrl2 ? ctrl2_q :
    hit_em ? em_base_q :
    hit_lstat ? lstat : rlcc_pkg::ZERO32;

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = rdata_q;
  assign strobe_o = strobe_q;
  assign rft_stop_o = rft_stop_q;
  assign rf_off_o = rf_off_q;

  // bus handshake: answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req && mapped;
  end

  // unmapped addresses answer with an error and change nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      err_q <= 1'b0;
    else
      err_q <= req && !mapped;
  end

  // read data is zero outside the answering cycle so stale values never leak
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= rlcc_pkg::ZERO32;
    else
      rdata_q <= (req && !we_i) ? rmux : rlcc_pkg::ZERO32;
  end

  // control register; a pending register reset wipes the block next cycle
  always_ff @(posedge clk_i)
  begin
    if (reg_rst)
      ctrl_q <= rlcc_pkg::CTRL_RESET;
    else
    begin
      // action bit 28 is held one cycle only, to feed the status
      ctrl_q[rlcc_pkg::BIT_SWI] <= go_swi;
      if (ctrl_wr)
      begin
        ctrl_q[rlcc_pkg::BIT_REG_RST] <= wbits[rlcc_pkg::BIT_REG_RST];
        ctrl_q[rlcc_pkg::BIT_MORE_DATA_DISABLE] <= wbits[rlcc_pkg::BIT_MORE_DATA_DISABLE];
        ctrl_q[rlcc_pkg::BIT_SEQNUM_DISABLE] <= wbits[rlcc_pkg::BIT_SEQNUM_DISABLE];
        ctrl_q[20:0] <= wbits[20:0] & rlcc_pkg::CTRL_RW_MASK[20:0];
      end
    end
  end

  // coexistence priority, merged per byte lane
  always_ff @(posedge clk_i)
  begin
    if (reg_rst)
      prio1_q <= rlcc_pkg::ZERO32;
    else if (wr && hit_prio1)
      prio1_q <= (prio1_q & ~bmask) | wbits;
  end

  // second control register, merged per byte lane
  always_ff @(posedge clk_i)
  begin
    if (reg_rst)
      ctrl2_q <= rlcc_pkg::ZERO32;
    else if (wr && hit_ctrl2)
      ctrl2_q <= (ctrl2_q & ~bmask) | wbits;
  end

  // exchange memory base, merged per byte lane
  always_ff @(posedge clk_i)
  begin
    if (reg_rst)
      em_base_q <= rlcc_pkg::ZERO32;
    else if (wr && hit_em)
      em_base_q <= (em_base_q & ~bmask) | wbits;
  end

  // interrupt mask belongs to the register block and is wiped with it
  always_ff @(posedge clk_i)
  begin
    if (reg_rst)
      mask_q <= rlcc_pkg::IRQ_MASK_RESET;
    else if (wr && hit_mask)
      mask_q <= wbits[rlcc_pkg::IRQ_W-1:0];
  end

  // interrupt status survives a register block reset; set beats clear
  for (genvar g = 0; g < rlcc_pkg::IRQ_W; g++)
  begin : g_stat
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        stat_q[g] <= 1'b0;
      else if (ev[g])
        stat_q[g] <= 1'b1;
      else if (ack_clr[g])
        stat_q[g] <= 1'b0;
    end
  end

  // one-cycle action strobes towards the core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      strobe_q <= '0;
    else
    begin
      strobe_q.core_rst <= go_core;
      strobe_q.tg_rst <= go_tg;
      strobe_q.adv_abort <= go_adv;
      strobe_q.scan_abort <= go_scan;
    end
  end

  // rf test abort: tx drains byte then crc, rx waits for packet end if synced
  always_ff @(posedge clk_i)
  begin
    if (rst_i || strobe_q.core_rst)
    begin
      rft_q <= rlcc_pkg::RLCC_RFT_IDLE;
      rft_cnt_q <= '0;
      rft_stop_q <= 1'b0;
      rf_off_q <= 1'b0;
    end
    else
    begin
      rft_stop_q <= 1'b0;
      rf_off_q <= 1'b0;
      case (rft_q)
        rlcc_pkg::RLCC_RFT_IDLE:
          if (rft_take)
          begin
            if (rft_is_tx_i)
            begin
              rft_q <= rlcc_pkg::RLCC_RFT_BYTE;
              rft_cnt_q <= 5'(rlcc_pkg::BYTE_BITS);
            end
            else if (rft_aa_found_i)
              rft_q <= rlcc_pkg::RLCC_RFT_PKT;
            else
            begin
              rft_stop_q <= 1'b1;
              rf_off_q <= 1'b1;
            end
          end
        rlcc_pkg::RLCC_RFT_BYTE:
          if (rft_bit_tick_i)
          begin
            if (rft_cnt_q == 5'h01)
            begin
              rft_q <= rlcc_pkg::RLCC_RFT_CRC;
              rft_cnt_q <= rlcc_pkg::CRC_BITS;
            end
            else
              rft_cnt_q <= rft_cnt_q - 5'h01;
          end
        rlcc_pkg::RLCC_RFT_CRC:
          if (rft_bit_tick_i)
          begin
            if (rft_cnt_q == 5'h01)
            begin
              rft_q <= rlcc_pkg::RLCC_RFT_IDLE;
              rft_stop_q <= 1'b1;
              rf_off_q <= 1'b1;
            end
            else
              rft_cnt_q <= rft_cnt_q - 5'h01;
          end
        rlcc_pkg::RLCC_RFT_PKT:
          if (rft_pkt_end_i)
          begin
            rft_q <= rlcc_pkg::RLCC_RFT_IDLE;
            rft_stop_q <= 1'b1;
            rf_off_q <= 1'b1;
          end
        default:
          rft_q <= rlcc_pkg::RLCC_RFT_IDLE;
      endcase
    end
  end
endmodule : rlcc_core_control

// ===== rtl/rlcc_pkg.sv
// package for the radio link core control block: register map, fields, structs
package rlcc_pkg;
  localparam logic [31:0] ADDR_CTRL = 32'h4000_0000;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h4000_0010;
  localparam logic [31:0] ADDR_IRQ_ACK = 32'h4000_0018;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_000c;
  localparam logic [31:0] ADDR_PRIO1 = 32'h4000_010c;
  localparam logic [31:0] ADDR_CTRL2 = 32'h4000_0200;
  localparam logic [31:0] ADDR_EM_BASE = 32'h4000_0208;
  localparam logic [31:0] ADDR_DBG2 = 32'h4000_020c;
  localparam logic [31:0] ADDR_DBG3 = 32'h4000_0210;
  localparam logic [31:0] ADDR_LINK_STAT = 32'h4000_0214;

  localparam int BIT_CORE_RST = 31;
  localparam int BIT_TG_RST = 30;
  localparam int BIT_REG_RST = 29;
  localparam int BIT_SWI = 28;
  localparam int BIT_RFT_ABORT = 26;
  localparam int BIT_ADV_ABORT = 25;
  localparam int BIT_SCAN_ABORT = 24;
  localparam int BIT_MORE_DATA_DISABLE = 22;
  localparam int BIT_SEQNUM_DISABLE = 21;

  // stored control bits: 29, 22, 21 and bits 13:12, 9:8, 6:4 and 2:0
  localparam logic [31:0] CTRL_RW_MASK = 32'h2060_3377;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // interrupt status/mask layout
  localparam int IRQ_W = 5;
  localparam int IRQ_SW = 0;
  localparam int IRQ_RFT_DONE = 1;
  localparam int IRQ_ADV_DONE = 2;
  localparam int IRQ_SCAN_DONE = 3;
  localparam int IRQ_SN_ERR = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // rf test abort sequence length: a tx abort stops a byte plus crc, 32 bit ticks, later
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] CRC_BITS = 5'h18;

  typedef enum logic [1:0] {
    RLCC_RFT_IDLE = 2'b00,
    RLCC_RFT_BYTE = 2'b01,
    RLCC_RFT_CRC = 2'b11,
    RLCC_RFT_PKT = 2'b10
  } rlcc_rft_e;

  // strobes towards the link engine
  typedef struct packed {
    logic core_rst;
    logic tg_rst;
    logic adv_abort;
    logic scan_abort;
  } rlcc_strobe_s;

  // per-packet flags taken from descriptors and the receiver
  typedef struct packed {
    logic tx_md;
    logic tx_sn;
    logic rx_md;
    logic rx_sn;
    logic exp_sn;
  } rlcc_pkt_s;
endpackage : rlcc_pkg

// ===== verif/rlcc_core_control_properties.sv
// concurrent checks on the control register bank ports
`timescale 1ns/10ps
module rlcc_core_control_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // packet flags and events
  input wire rlcc_pkg::rlcc_pkt_s pkt_i,
  input wire logic rx_done_i,
  input wire logic tx_sn_o,
  input wire logic rx_md_store_o,
  input wire logic sn_err_o,
  input wire rlcc_pkg::rlcc_strobe_s strobe_o,
  input wire logic software_irq_out,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request is taken only while ack is low, so one write gives one strobe
  wire ctl = cyc_i & stb_i & ~ack_o & (adr_i == rlcc_pkg::ADDR_CTRL) & sel_i[3];
  wire wr = ctl & we_i;
  wire rd = ctl & ~we_i;
  // shadow of the sequence number disable bit, tracked from control writes
  logic seqnum_disable_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seqnum_disable_q <= 1'b0;
    else if (wr)
      seqnum_disable_q <= dat_i[21] & sel_i[2] & ~dat_i[29];
  end
  property p_core_rst;
    wr && dat_i[31] |=> strobe_o.core_rst ##1 !strobe_o.core_rst;
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("core reset strobe not one cycle");
  property p_zero_write;
    wr && dat_i[31:24] == 8'h00 |=> strobe_o == 4'h0;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("strobe after zero write");
  property p_swi_level;
    software_irq_out |-> irq_o;
  endproperty
  a_swi_level: assert property (p_swi_level) else $error("software irq without irq");
  property p_adv_abort;
    wr && dat_i[25] |=> strobe_o.adv_abort ##1 !strobe_o.adv_abort;
  endproperty
  a_adv_abort: assert property (p_adv_abort) else $error("advertising abort strobe wrong");
  property p_rx_md;
    rx_md_store_o == pkt_i.rx_md;
  endproperty
  a_rx_md: assert property (p_rx_md) else $error("received md flag not stored");
  property p_tx_sn;
    tx_sn_o == (seqnum_disable_q ? pkt_i.tx_sn : pkt_i.exp_sn);
  endproperty
  a_tx_sn: assert property (p_tx_sn) else $error("sequence number source wrong");
  property p_sn_err;
    sn_err_o |-> rx_done_i && !seqnum_disable_q && pkt_i.rx_sn != pkt_i.exp_sn;
  endproperty
  a_sn_err: assert property (p_sn_err) else $error("sequence error without cause");
  property p_strobe_read;
    rd |=> (dat_o & 32'hf700_0000) == 32'h0000_0000;
  endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("strobe bits read nonzero");
endmodule : rlcc_core_control_properties
bind rlcc_core_control rlcc_core_control_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .pkt_i(pkt_i), .rx_done_i(rx_done_i), .tx_sn_o(tx_sn_o), .rx_md_store_o(rx_md_store_o), .sn_err_o(sn_err_o),
  .strobe_o(strobe_o), .software_irq_out(software_irq_out), .irq_o(irq_o));

// ===== verif/tb_radio_link_core_control.sv
// self-checking bench for the core control register bank
`timescale 1ns/10ps
module tb_radio_link_core_control;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'hf;
  logic ack_o, err_o, stop, off, tx_md_o, tx_sn_o, md_st, sn_err_o, more, swi, irq_o, lerr;
  logic act = 1'b0, istx = 1'b0, tick = 1'b0, aa = 1'b0, pend = 1'b0, rxd = 1'b0, mdp = 1'b0;
  rlcc_pkg::rlcc_pkt_s pkt = 5'h00;
  rlcc_pkg::rlcc_strobe_s stb;
  logic [5:0] ev;
  int mismatches = 0, compares = 0, n;
  always #4 clk_i = ~clk_i;
  rlcc_core_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .rft_active_i(act), .rft_is_tx_i(istx), .rft_bit_tick_i(tick), .rft_aa_found_i(aa),
    .rft_pkt_end_i(pend), .rft_stop_o(stop), .rf_off_o(off), .pkt_i(pkt), .rx_done_i(rxd),
    .md_peer_i(mdp), .tx_md_o(tx_md_o), .tx_sn_o(tx_sn_o), .rx_md_store_o(md_st), .sn_err_o(sn_err_o),
    .more_exchange_o(more), .strobe_o(stb), .software_irq_out(swi), .irq_o(irq_o));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one classic cycle; events are captured at the edge that sees the answer
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    @(posedge clk_i);
    while (!(ack_o | err_o))
      @(posedge clk_i);
    rd = dat_o;
    lerr = err_o;
    ev = {stop, off, stb};
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask : rdc
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    final_report();
  end
  initial
  begin
    int bt[4] = '{31, 30, 25, 24};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("ctrl", rlcc_pkg::ADDR_CTRL, 32'h0);
    wb(1'b0, 32'h4000_0004, 32'h0);
    check("err", lerr, 1'b1);
    wb(1'b1, rlcc_pkg::ADDR_DBG2, 32'hffff_ffff);
    rdc("dbg2", rlcc_pkg::ADDR_DBG2, 32'h0);
    $display("test map done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h1 << bt[i]);
      check("strobe", ev, 6'h08 >> i);
    end
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h0);
    check("nostrobe", ev, 6'h00);
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'hdf60_3377);
    check("allstrobe", ev, 6'h0f);
    rdc("readback", rlcc_pkg::ADDR_CTRL, 32'h0060_3377);
    $display("test strobes done");
    rdc("status", rlcc_pkg::ADDR_IRQ_STAT, 32'h0d);
    check("masked", {swi, irq_o}, 2'b00);
    wb(1'b1, rlcc_pkg::ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    check("unmasked", {swi, irq_o}, 2'b11);
    wb(1'b1, rlcc_pkg::ADDR_IRQ_ACK, 32'h1f);
    repeat (2) @(posedge clk_i);
    check("acked", {swi, irq_o}, 2'b00);
    $display("test irq done");
    wb(1'b1, rlcc_pkg::ADDR_PRIO1, 32'hffff_ffff);
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h1000_0000);
    sel_i <= 4'h8;
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h2000_0000);
    sel_i <= 4'hf;
    repeat (3) @(posedge clk_i);
    rdc("ctrl", rlcc_pkg::ADDR_CTRL, 32'h0);
    rdc("mask", rlcc_pkg::ADDR_IRQ_MASK, 32'h0);
    rdc("prio1", rlcc_pkg::ADDR_PRIO1, 32'h0);
    rdc("kept", rlcc_pkg::ADDR_IRQ_STAT, 32'h1);
    wb(1'b1, rlcc_pkg::ADDR_IRQ_ACK, 32'h1f);
    rdc("cleared", rlcc_pkg::ADDR_IRQ_STAT, 32'h0);
    $display("test register reset done");
    pkt <= 5'b11010;
    rxd <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("normal", {tx_md_o, tx_sn_o, more, sn_err_o}, 4'b0011);
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h0060_0000);
    @(posedge clk_i);
    check("disabled", {tx_md_o, tx_sn_o, more, sn_err_o, md_st}, 5'b11000);
    rxd <= 1'b0;
    $display("test descriptors done");
    act <= 1'b1;
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h0400_0000);
    check("rx abort", ev, 6'h30);
    aa <= 1'b1;
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h0400_0000);
    check("rx wait", ev, 6'h00);
    repeat (3) @(posedge clk_i);
    pend <= 1'b1;
    @(posedge clk_i);
    pend <= 1'b0;
    @(posedge clk_i);
    check("rx end", stop, 1'b1);
    {istx, aa, tick} <= 3'b101;
    wb(1'b1, rlcc_pkg::ADDR_CTRL, 32'h0400_0000);
    for (n = 0; !stop && n < 100; n++)
      @(posedge clk_i);
    check("tx bits", n, 32'h0000_0020);
    act <= 1'b0;
    $display("test rf abort done");
    final_report();
  end
endmodule : tb_radio_link_core_control
